// ==== hw/asr_params.svh ====
// Purpose: timing counts and widths for the static memory host controller
// Assumes: 125 MHz clock, 8 ns period
// Notes: times in ns; cycle counts derived and rounded up for minimums
`ifndef ASR_PARAMS_SVH
`define ASR_PARAMS_SVH
`define ASR_CLK_PERIOD_NS 8
`define ASR_ADDR_W 13
`define ASR_DATA_W 8
`define ASR_WORDS 8192
// slowest grade figures
`define ASR_T_RC_NS 70
`define ASR_T_WP_NS 50
`define ASR_T_DW_NS 35
`define ASR_T_HZ_NS 30
`define ASR_RD_CYC ((`ASR_T_RC_NS + `ASR_CLK_PERIOD_NS - 1) / `ASR_CLK_PERIOD_NS)
`define ASR_WP_CYC ((`ASR_T_WP_NS + `ASR_CLK_PERIOD_NS - 1) / `ASR_CLK_PERIOD_NS)
`define ASR_HZ_CYC ((`ASR_T_HZ_NS + `ASR_CLK_PERIOD_NS - 1) / `ASR_CLK_PERIOD_NS)
`endif

// ==== hw/asr_pkg.sv ====
// Purpose: types for the static memory host controller
// Assumes: nothing
// Notes: gray codes along idle-setup-strobe-recover
package asr_pkg;
	typedef enum logic [2:0] {
		ASR_IDLE = 3'h0,
		ASR_SETUP = 3'h1,
		ASR_STROBE = 3'h3,
		ASR_RECOVER = 3'h2,
		ASR_SLEEP = 3'h6
	} asr_state_e;
	typedef logic [3:0] asr_cnt_t;
endpackage

// ==== hw/asr_sync.sv ====
// Purpose: two flip-flop synchroniser for the data bus inputs
// Assumes: one clock
// Notes: first stage read only by second
`timescale 1ns/1ns
module asr_sync (
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_rst_n,
	// async in, synced out
	input wire logic [7:0] i_d,
	output logic [7:0] o_q
);
	logic [7:0] meta_reg;
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			meta_reg <= 8'h00;
			o_q <= 8'h00;
		end else begin
			meta_reg <= i_d;
			o_q <= meta_reg;
		end
	end
endmodule // asr_sync

// ==== hw/asr_host.sv ====
// What this block does
// - write only when both selects and strobe overlap
// - strobe held high for whole read
// - no opposing data while device may drive
// - low-select standby keeps high select high
// Purpose: host controller driving an asynchronous 8k x 8 static memory
// Assumes: one request at a time; i_req taken only when o_ready high
// Notes: low select changes together with the address/data setup; the high select stays high; write strobe falls one cycle later
`timescale 1ns/1ns
`include "asr_params.svh"
module asr_host (
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_rst_n,
	// user request
	input wire logic i_req,
	input wire logic i_wr,
	input wire logic [12:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_sleep,
	output logic o_ready,
	output logic o_rvalid,
	output logic [7:0] o_rdata,
	// memory pins
	output logic [12:0] o_mem_addr,
	output logic o_select_low_active_n,
	output logic o_select_high_active,
	output logic o_we_n,
	output logic o_oe_n,
	output logic [7:0] o_dq,
	output logic o_dq_oe,
	input wire logic [7:0] i_dq
);
	asr_pkg::asr_state_e state_reg, state_next;
	asr_pkg::asr_cnt_t cnt_reg, cnt_next;
	logic wr_reg;
	logic [7:0] dq_sync;
	localparam asr_pkg::asr_cnt_t RD_CNT = asr_pkg::asr_cnt_t'(`ASR_RD_CYC + 2);
	localparam asr_pkg::asr_cnt_t WP_CNT = asr_pkg::asr_cnt_t'(`ASR_WP_CYC);
	localparam asr_pkg::asr_cnt_t HZ_CNT = asr_pkg::asr_cnt_t'(`ASR_HZ_CYC);

	asr_sync u_sync (
		.i_mclk(i_mclk),
		.i_rst_n(i_rst_n),
		.i_d(i_dq),
		.o_q(dq_sync)
	);

	wire idle_w = (state_reg == asr_pkg::ASR_IDLE);
	wire take_w = idle_w && i_req && !i_sleep;
	wire cnt_done_w = (cnt_reg == 4'h0);
	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		case (state_reg)
			asr_pkg::ASR_IDLE: begin
				if (i_sleep) begin
					state_next = asr_pkg::ASR_SLEEP;
				end else if (i_req) begin
					state_next = asr_pkg::ASR_SETUP;
					cnt_next = 4'h0;
				end
			end
			asr_pkg::ASR_SETUP: begin
				state_next = asr_pkg::ASR_STROBE;
				cnt_next = wr_reg ? WP_CNT : RD_CNT;
			end
			asr_pkg::ASR_STROBE: begin
				if (cnt_done_w) begin
					state_next = asr_pkg::ASR_RECOVER;
					cnt_next = HZ_CNT;
				end else begin
					cnt_next = cnt_reg - 4'h1;
				end
			end
			asr_pkg::ASR_RECOVER: begin
				// bus turnaround gap before next select
				if (cnt_done_w) begin
					state_next = asr_pkg::ASR_IDLE;
				end else begin
					cnt_next = cnt_reg - 4'h1;
				end
			end
			asr_pkg::ASR_SLEEP: begin
				if (!i_sleep) begin
					state_next = asr_pkg::ASR_IDLE;
				end
			end
			default: begin
				state_next = asr_pkg::ASR_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			state_reg <= asr_pkg::ASR_IDLE;
			cnt_reg <= 4'h0;
			wr_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			if (take_w) begin
				wr_reg <= i_wr;
			end
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			o_mem_addr <= 13'h0000;
			o_dq <= 8'h00;
		end else if (take_w) begin
			o_mem_addr <= i_addr;
			o_dq <= i_wdata;
		end
	end

	// pins registered from next-state decode
	wire nx_sel_w = (state_next == asr_pkg::ASR_SETUP) || (state_next == asr_pkg::ASR_STROBE);
	wire nx_wr_w = take_w ? i_wr : wr_reg;
	// write strobe only in the strobe phase of a write
	wire nx_we_n_w = !(nx_wr_w && state_next == asr_pkg::ASR_STROBE);
	// outputs enabled only for reads, host data only for writes
	wire nx_oe_n_w = !(nx_sel_w && !nx_wr_w);
	wire nx_dq_oe_w = nx_sel_w && nx_wr_w;
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			o_select_low_active_n <= 1'b1;
			o_select_high_active <= 1'b1;
			o_we_n <= 1'b1;
			o_oe_n <= 1'b1;
			o_dq_oe <= 1'b0;
		end else begin
			o_select_low_active_n <= !nx_sel_w;
			o_select_high_active <= 1'b1;
			o_we_n <= nx_we_n_w;
			o_oe_n <= nx_oe_n_w;
			o_dq_oe <= nx_dq_oe_w;
		end
	end

	// read data captured at end of strobe, after two sync stages
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			o_rdata <= 8'h00;
			o_rvalid <= 1'b0;
			o_ready <= 1'b0;
		end else begin
			o_rvalid <= 1'b0;
			if (state_reg == asr_pkg::ASR_STROBE && cnt_done_w && !wr_reg) begin
				o_rdata <= dq_sync;
				o_rvalid <= 1'b1;
			end
			o_ready <= (state_next == asr_pkg::ASR_IDLE) && !i_sleep;
		end
	end

	// pin-level checks on what the host drives
	sequence wr_strobe_s;
		!o_we_n && !o_select_low_active_n && o_select_high_active;
	endsequence
	sequence write_setup_s;
		!o_select_low_active_n && o_select_high_active && o_dq_oe && o_we_n && o_oe_n;
	endsequence
	sequence read_access_s;
		!o_select_low_active_n && o_select_high_active && !o_oe_n && o_we_n && !o_dq_oe;
	endsequence

	property write_overlap_p;
		@(posedge i_mclk) disable iff (!i_rst_n) !o_we_n |-> o_dq_oe and wr_strobe_s;
	endproperty
	// a write opens with one setup cycle, then the strobe stays low
	property write_steps_p;
		@(posedge i_mclk) disable iff (!i_rst_n)
		$fell(o_select_low_active_n) ##0 write_setup_s |=> wr_strobe_s [*7];
	endproperty
	// a read keeps the strobe high for the first 8 cycles that the outputs are enabled
	property read_steps_p;
		@(posedge i_mclk) disable iff (!i_rst_n)
		$fell(o_oe_n) |-> read_access_s [*8];
	endproperty

	write_overlap_a: assert property (write_overlap_p)
		else $error("strobe without select");
	write_steps_a: assert property (write_steps_p)
		else $error("write steps out of order");
	read_steps_a: assert property (read_steps_p)
		else $error("strobe or drive during read");
	read_strobe_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		!o_oe_n |-> o_we_n) else $error("strobe low in read");
	no_fight_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		o_dq_oe |-> o_oe_n) else $error("drive while outputs enabled");
	high_sel_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		o_select_high_active) else $error("high select dropped");
	standby_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		state_reg == asr_pkg::ASR_SLEEP |-> o_select_low_active_n && o_we_n && !o_dq_oe)
		else $error("access during standby");
	turnaround_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		$rose(o_select_low_active_n) |=> o_select_low_active_n [*3])
		else $error("reselect too soon");
	ready_idle_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		o_ready |-> o_select_low_active_n && o_oe_n && !o_dq_oe)
		else $error("bus held while ready");
	write_width_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		$fell(o_we_n) |-> !o_we_n [*7]) else $error("write pulse short");
	addr_still_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		!o_select_low_active_n && !$past(o_select_low_active_n) |-> $stable(o_mem_addr))
		else $error("address moved while selected");
	data_still_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		o_dq_oe && $past(o_dq_oe) |-> $stable(o_dq)) else $error("write data moved");
	rvalid_time_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		o_rvalid |-> !$past(o_oe_n)) else $error("read data without read");
	rvalid_pulse_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		o_rvalid |=> !o_rvalid) else $error("read data pulse too long");
	we_after_sel_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		$fell(o_we_n) |-> !$past(o_select_low_active_n))
		else $error("strobe before select");
	dq_when_sel_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		o_dq_oe |-> !o_select_low_active_n)
		else $error("data without select");
endmodule // asr_host

// ==== testbench/asr_sram_model.sv ====
// Purpose: behavioural 8k x 8 static memory on the host pins
// Assumes: level driven, no clock
// Notes: o_clash flags both sides driving the bus
`timescale 1ns/1ns
module asr_sram_model (
	// memory pins
	input wire logic [12:0] i_addr,
	input wire logic i_sel_n,
	input wire logic i_sel_h,
	input wire logic i_we_n,
	input wire logic i_oe_n,
	input wire logic [7:0] i_dq,
	input wire logic i_host_oe,
	// device drive
	output logic [7:0] o_dq,
	output logic o_dq_oe,
	output logic o_clash
);
	logic [7:0] mem [0:8191];
	logic sel;
	assign sel = !i_sel_n && i_sel_h;
	assign o_dq_oe = sel && !i_oe_n && i_we_n;
	assign o_dq = mem[i_addr];
	assign o_clash = o_dq_oe && i_host_oe;
	always @* begin
		if (sel && !i_we_n) begin
			mem[i_addr] = i_dq;
		end
	end
endmodule // asr_sram_model

// ==== testbench/tb_asr_host.sv ====
// Purpose: self-checking bench for the static memory host
// Assumes: read answer 13 cycles after the take edge
// Notes: undriven bus shows the inverse of the host data
`timescale 1ns/1ns
module tb_asr_host;
	logic i_mclk, i_rst_n, i_req, i_wr, i_sleep, o_ready, o_rvalid;
	logic [12:0] i_addr, o_mem_addr;
	logic [7:0] i_wdata, o_rdata, o_dq, m_dq, i_dq;
	logic o_sel_n, o_sel_h, o_we_n, o_oe_n, o_dq_oe, m_oe, clash;
	int errors, n_compared, cycles;
	assign i_dq = o_dq_oe ? o_dq : (m_oe ? m_dq : ~o_dq);
	asr_host uut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_req(i_req), .i_wr(i_wr),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_sleep(i_sleep), .o_ready(o_ready),
		.o_rvalid(o_rvalid), .o_rdata(o_rdata), .o_mem_addr(o_mem_addr),
		.o_select_low_active_n(o_sel_n), .o_select_high_active(o_sel_h),
		.o_we_n(o_we_n), .o_oe_n(o_oe_n), .o_dq(o_dq), .o_dq_oe(o_dq_oe), .i_dq(i_dq));
	asr_sram_model dev (.i_addr(o_mem_addr), .i_sel_n(o_sel_n), .i_sel_h(o_sel_h),
		.i_we_n(o_we_n), .i_oe_n(o_oe_n), .i_dq(i_dq), .i_host_oe(o_dq_oe),
		.o_dq(m_dq), .o_dq_oe(m_oe), .o_clash(clash));
	initial begin
		i_mclk = 0;
		forever #4 i_mclk = ~i_mclk;
	end
	task automatic check(input logic ok, input string msg);
		n_compared++;
		if (ok !== 1'b1) begin
			errors++;
			$display("MISMATCH %0t %s", $time, msg);
		end
	endtask
	task automatic complete_run();
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	always @(posedge i_mclk) begin
		cycles++;
		if (i_rst_n) check(!(clash === 1'b1), "bus clash");
		if (i_rst_n) check(!(o_oe_n === 1'b0 && o_we_n !== 1'b1), "strobe in read");
		if (cycles == 6000) begin
			errors++;
			$display("MISMATCH %0t timeout", $time);
			complete_run();
		end
	end
	task automatic go(input logic wr, input logic [12:0] a, input logic [7:0] d);
		int n;
		for (n = 0; n < 40 && o_ready !== 1'b1; n++) @(posedge i_mclk) #1;
		{i_req, i_wr, i_addr, i_wdata} = {1'b1, wr, a, d};
		@(posedge i_mclk) #1 i_req = 0;
	endtask
	task automatic rd(input logic [12:0] a, input logic [7:0] exp);
		int n;
		go(0, a, 8'h00);
		for (n = 1; n < 30 && o_rvalid !== 1'b1; n++) @(posedge i_mclk) #1;
		check(n == 14, "read latency");
		check(o_rdata === exp, "read data");
	endtask
	task automatic t_bounds(); // write at both address ends, back to back
		go(1, 13'h0000, 8'ha5);
		go(1, 13'h1fff, 8'h3c);
		go(1, 13'h1000, 8'hff);
		rd(13'h0000, 8'ha5);
		rd(13'h1fff, 8'h3c);
		rd(13'h1000, 8'hff);
	endtask
	task automatic t_refuse(); // request while busy is ignored
		go(1, 13'h0005, 8'h11);
		@(posedge i_mclk) #1;
		{i_req, i_wdata} = {1'b1, 8'h22};
		@(posedge i_mclk) #1 i_req = 0;
		check(o_dq === 8'h11 && o_sel_n === 1'b0, "refused request took effect");
		rd(13'h0005, 8'h11);
	endtask
	task automatic t_sleep(); // standby keeps the high select up and refuses requests
		i_sleep = 1;
		{i_req, i_wr, i_addr, i_wdata} = {1'b1, 1'b1, 13'h0000, 8'h77};
		repeat (8) @(posedge i_mclk) #1;
		check(o_sel_n === 1'b1 && o_sel_h === 1'b1, "standby selects");
		check(o_ready === 1'b0, "ready in standby");
		{i_sleep, i_req} = 2'b00;
		rd(13'h0000, 8'ha5);
	endtask
	task automatic t_reset(); // reset in mid-write drops strobe and select at once
		go(1, 13'h0100, 8'h5a);
		repeat (3) @(posedge i_mclk) #1;
		check(o_we_n === 1'b0, "strobe before reset");
		i_rst_n = 0;
		repeat (2) @(posedge i_mclk) #1;
		i_rst_n = 1;
		check(o_sel_n === 1'b1 && o_we_n === 1'b1 && o_dq_oe === 1'b0, "pins after reset");
		check(o_sel_h === 1'b1 && o_ready === 1'b0, "select after reset");
		@(posedge i_mclk) #1;
		check(o_ready === 1'b1, "ready after reset");
		rd(13'h1fff, 8'h3c);
	endtask
	initial begin
		{i_rst_n, i_req, i_wr, i_sleep, i_addr, i_wdata} = '0;
		repeat (20) @(posedge i_mclk);
		#1 i_rst_n = 1;
		check(o_sel_n === 1'b1 && o_we_n === 1'b1 && o_dq_oe === 1'b0, "idle pins");
		check(o_sel_h === 1'b1 && o_oe_n === 1'b1 && o_ready === 1'b0, "idle state");
		t_bounds();
		t_refuse();
		t_sleep();
		t_reset();
		complete_run();
	end
endmodule // tb_asr_host
